// ### asc_pkg.sv
package asc_pkg;
  // Notes on behaviour
  // - Three interrupts, error above completion above transmit.
  // - Error interrupt ORs errors, only while receiving.
  // - Errored frame still buffered; both interrupts together.
  // - One transmit interrupt per frame, any length.
  // - Transmit interrupt as the last bit starts.
  // - Frame is start, character, parity/expansion, stops.
  // - Transmitter and receiver run independently.
  // - Enabled write starts frame, start bit, LSB first.
  // - Writes ignored while transmit is disabled.
  // - Writes before transmit interrupt are discarded.
  // - Reset emptying the shifter raises no interrupt.
  // - No clear-to-send gating of the transmitter.
  // - Receive disabled holds receiver idle, buffer kept.
  // - Confirm start after 8 ticks, bits every 16.
  // - High at confirm rejects start, restarts timing.
  // - Completed frame goes to buffer with interrupt.
  // - Receive disable mid-frame aborts, nothing changes.
  // - Parity, framing and overrun flags per frame.
  // - Flags clear on buffer read or next frame.
  // - Length selects 7 or 8 bits, stop 1 or 2.
  // - Overrun overwrites the unread buffer.
  // - Buffer is 9 bits, unused upper bits zero.

  // Serial clock ticks per bit and to the start confirm
  localparam logic [3:0] BIT_TICK_LAST = 4'h000F;
  localparam logic [3:0] HALF_TICK_LAST = 4'h0007;
  // Parity mode codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // Highest pending interrupt code
  localparam logic [1:0] IRQ_NONE = 2'h0;
  localparam logic [1:0] IRQ_RX_ERR = 2'h1;
  localparam logic [1:0] IRQ_RX_DONE = 2'h2;
  localparam logic [1:0] IRQ_TX_DONE = 2'h3;
  // Widths and reset values
  localparam int unsigned CHAR_W = 9;
  localparam int unsigned FRAME_W = 12;
  localparam logic [8:0] RXB_RST = 9'h0000;
  localparam logic [11:0] FRAME_IDLE = 12'h0FFF;
  // Error status bit positions
  localparam int unsigned ERR_PE = 2;
  localparam int unsigned ERR_FE = 1;
  localparam int unsigned ERR_OVE = 0;

  // Number of character bits, 7 or 8
  function automatic logic [3:0] char_bits(input logic cl);
    return cl ? 4'h0008 : 4'h0007;
  endfunction

  // Parity bit for a character under the given mode
  function automatic logic par_calc(input logic [8:0] d,
                                    input logic cl,
                                    input logic [1:0] pm);
    logic x;
    x = ^(cl ? d[7:0] : {1'b0, d[6:0]});
    unique case (pm)
      PAR_ODD: return ~x;
      PAR_EVEN: return x;
      PAR_NONE, PAR_ZERO: return 1'b0;
    endcase
  endfunction
endpackage

// ### asc_core_if.sv
`timescale 1ns/1ns
// Links the top with its transmitter and start-bit sampler
interface asc_core_if;
  logic tick; // Serial clock tick, 16 per bit
  logic tx_go; // Load a new frame
  logic [11:0] tx_frame; // Frame bits, bit 0 first
  logic [3:0] tx_len; // Frame length in bits
  logic tx_line; // Serial output level
  logic tx_last; // Last bit starts now
  logic tx_busy; // Frame accepted, last bit not started
  logic rx_line; // Receive pin level
  logic rx_hold; // Force the sampler idle
  logic rx_start; // Start bit confirmed
  logic rx_bit_stb; // Mid-bit sample point
  modport tx_mp(input tick, tx_go, tx_frame, tx_len,
                output tx_line, tx_last, tx_busy);
  modport tx_ctl(output tick, tx_go, tx_frame, tx_len,
                 input tx_line, tx_last, tx_busy);
  modport smp_mp(input tick, rx_line, rx_hold,
                 output rx_start, rx_bit_stb);
  modport smp_ctl(output rx_line, rx_hold,
                  input rx_start, rx_bit_stb);
endinterface

// ### asc_tx.sv
`timescale 1ns/1ns
module asc_tx (
  input wire logic clock_in,
  input wire logic srst_in,
  asc_core_if.tx_mp cif
);
  import asc_pkg::*;

  typedef enum logic {T_IDLE, T_RUN} asc_tx_e;
  typedef struct packed {
    asc_tx_e st; // Shifter state
    logic [11:0] sh; // Remaining frame bits
    logic [3:0] left; // Bits still to start
    logic [3:0] cnt; // Tick count inside a bit
    logic last; // Last-bit pulse
    logic busy; // Writes refused while set
    logic pend; // Next frame waits for last bit end
    logic [11:0] nfr; // Waiting frame
    logic [3:0] nlen; // Waiting frame length
  } asc_tx_s;

  asc_tx_s q;
  asc_tx_s d;

  // Next state of the shifter
  always_comb begin
    d = q;
    d.last = 1'b0;
    // Go only arrives while not busy, so no frame is lost
    if (cif.tx_go) begin
      d.busy = 1'b1;
      if (q.st == T_IDLE) begin
        d.st = T_RUN;
        d.sh = cif.tx_frame;
        d.left = cif.tx_len - 4'h0001;
        d.cnt = 4'h0000;
      end else begin
        // Last bit still on the line; chain right after it
        d.pend = 1'b1;
        d.nfr = cif.tx_frame;
        d.nlen = cif.tx_len;
      end
    end
    if (q.st == T_RUN && cif.tick) begin
      d.cnt = q.cnt + 4'h0001;
      if (q.cnt == BIT_TICK_LAST) begin
        d.cnt = 4'h0000;
        if (q.left == 4'h0000) begin
          // Frame finished; a write taken in this very cycle chains too,
          // otherwise busy would stay set with nothing left to send
          d.st = d.pend ? T_RUN : T_IDLE;
          d.sh = d.pend ? d.nfr : FRAME_IDLE;
          d.left = d.nlen - 4'h0001;
          d.pend = 1'b0;
        end else begin
          d.sh = {1'b1, q.sh[11:1]};
          d.left = q.left - 4'h0001;
          if (q.left == 4'h0001) begin
            // Interrupt as the last bit begins, once per frame
            d.last = 1'b1;
            d.busy = 1'b0;
          end
        end
      end
    end
  end

  // Reset empties the shifter silently, no last pulse
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '{st: T_IDLE, sh: FRAME_IDLE, nfr: FRAME_IDLE,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // Line is the low bit of the shifter, high when idle
  assign cif.tx_line = (q.st == T_IDLE) ? 1'b1 : q.sh[0];
  assign cif.tx_last = q.last;
  assign cif.tx_busy = q.busy;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  a_tx_idle_high: assert property (
    q.st == T_IDLE || cif.tx_last |-> cif.tx_line)
    else $error("tx line not idle");
  a_tx_last_once: assert property (
    cif.tx_last |=> !cif.tx_last && (!cif.tx_busy || $past(cif.tx_go)))
    else $error("tx done repeated");
endmodule

// ### asc_rx_smp.sv
`timescale 1ns/1ns
module asc_rx_smp (
  input wire logic clock_in,
  input wire logic srst_in,
  asc_core_if.smp_mp cif
);
  import asc_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_CONF, S_RUN} asc_smp_e;
  typedef struct packed {
    asc_smp_e st; // Sample timing state
    logic [3:0] cnt; // Serial clock tick counter
    logic start; // Start confirmed pulse
    logic stb; // Bit sample pulse
  } asc_smp_s;

  asc_smp_s q;
  asc_smp_s d;

  // Start detection and sample timing
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.stb = 1'b0;
    if (cif.rx_hold) begin
      d.st = S_IDLE;
      d.cnt = 4'h0000;
    end else if (cif.tick) begin
      unique case (q.st)
        S_IDLE: if (!cif.rx_line) begin
          d.st = S_CONF;
          d.cnt = 4'h0000;
        end
        S_CONF: if (q.cnt == HALF_TICK_LAST) begin
          d.cnt = 4'h0000;
          // Still low at the middle: a real start bit
          d.st = cif.rx_line ? S_IDLE : S_RUN;
          d.start = !cif.rx_line;
        end else begin
          d.cnt = q.cnt + 4'h0001;
        end
        S_RUN: if (q.cnt == BIT_TICK_LAST) begin
          d.cnt = 4'h0000;
          d.stb = 1'b1;
        end else begin
          d.cnt = q.cnt + 4'h0001;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '{st: S_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign cif.rx_start = q.start;
  assign cif.rx_bit_stb = q.stb;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  sequence s_confirm_point;
    q.st == S_CONF && cif.tick && q.cnt == HALF_TICK_LAST &&
      !cif.rx_hold;
  endsequence

  a_smp_false_start: assert property (
    s_confirm_point and cif.rx_line |=> q.st == S_IDLE && !q.start)
    else $error("false start accepted");
  a_smp_true_start: assert property (
    s_confirm_point and !cif.rx_line |=> q.start ##0 q.cnt == 4'h0000)
    else $error("start bit missed");
endmodule

// ### asc_top.sv
`timescale 1ns/1ns
module asc_top (
  input wire logic clock_in,
  input wire logic srst_in,
  // Serial clock tick from the baud generator, 16 per bit
  input wire logic sample_tick_in,
  // Mode settings
  input wire logic tx_enable_bit_in,
  input wire logic rx_enable_bit_in,
  input wire logic char_length_sel_in,
  input wire logic stop_length_sel_in,
  input wire logic [1:0] parity_mode_in,
  input wire logic ext_bit_en_in,
  // Transmit shift register write
  input wire logic tx_write_in,
  input wire logic [asc_pkg::CHAR_W-1:0] tx_shift_reg_in,
  // Receive buffer read strobe
  input wire logic rx_read_in,
  // Line pins
  input wire logic rx_pin_in,
  output logic tx_pin_out,
  // Software-visible state
  output logic tx_busy_out,
  output logic [asc_pkg::CHAR_W-1:0] rx_buffer_out,
  output logic [2:0] async_error_status_out,
  // Interrupt requests and highest pending one
  output logic rx_error_irq_out,
  output logic rx_done_irq_out,
  output logic tx_done_irq_out,
  output logic [1:0] irq_top_out
);
  import asc_pkg::*;

  // Receive frame phases
  typedef enum logic [1:0] {R_IDLE, R_DATA, R_STOP} asc_rx_e;

  typedef struct packed {
    asc_rx_e st; // Receive phase
    logic [3:0] idx; // Index of the next payload bit
    logic [8:0] sh; // Receive shift register
    logic pe_pend; // Parity mismatch of this frame
    logic [8:0] rxb; // Receive buffer
    logic [2:0] err; // Error status flags
    logic unread; // Buffer holds unread data
    logic err_irq; // Reception error pulse
    logic done_irq; // Reception completion pulse
    logic fin; // Frame ended, resets the sampler
    logic [1:0] top; // Highest pending interrupt
  } asc_top_s;

  asc_top_s q;
  asc_top_s d;

  asc_core_if cif();

  // Mode-derived widths
  logic [3:0] nchar; // Character bits, 7 or 8
  logic xbit; // One parity or expansion bit follows
  logic [3:0] npay; // Character plus parity or expansion
  logic [8:0] tx_pay; // Character with parity or expansion bit placed
  logic [11:0] tx_frm; // Whole transmit frame
  logic rx_fin; // Completion in this cycle
  logic rx_perr; // Parity error of the completing frame
  logic rx_ferr; // Framing error of the completing frame
  logic rx_ovr; // Overrun of the completing frame

  // Character layout from the mode settings
  always_comb begin
    nchar = char_bits(char_length_sel_in);
    xbit = (parity_mode_in != PAR_NONE) || ext_bit_en_in;
    npay = nchar + {3'h0, xbit};
  end

  // Frame assembly: start, character LSB first, extra, stops
  always_comb begin
    tx_pay = char_length_sel_in ? tx_shift_reg_in
                                : {2'h0, tx_shift_reg_in[6:0]};
    if (parity_mode_in != PAR_NONE) begin
      // Parity takes the slot after the character
      tx_pay[nchar] = par_calc(tx_shift_reg_in,
                               char_length_sel_in,
                               parity_mode_in);
    end else if (ext_bit_en_in) begin
      // Expansion bit is the written ninth bit
      tx_pay[nchar] = tx_shift_reg_in[8];
    end
    // Ones fill every slot above the payload as stop bits
    tx_frm = FRAME_IDLE;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < npay) begin
        tx_frm[i + 1] = tx_pay[i];
      end
    end
    tx_frm[0] = 1'b0;
  end

  // Transmit side: no flow-control input exists at all
  assign cif.tick = sample_tick_in;
  assign cif.tx_go = tx_write_in && tx_enable_bit_in &&
                     !cif.tx_busy;
  assign cif.tx_frame = tx_frm;
  // Start, payload, one or two stop bits
  assign cif.tx_len = npay + (stop_length_sel_in ? 4'h0003
                                                 : 4'h0002);

  // Transmitter runs on its own state, apart from the receiver
  asc_tx u_tx (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .cif(cif)
  );

  // Sampler is held idle while receive is off or a frame ends
  assign cif.rx_line = rx_pin_in;
  assign cif.rx_hold = !rx_enable_bit_in || q.fin;

  asc_rx_smp u_smp (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .cif(cif)
  );

  // Errors judged at the first stop bit sample
  always_comb begin
    rx_fin = rx_enable_bit_in && q.st == R_STOP &&
             cif.rx_bit_stb;
    rx_ferr = !rx_pin_in;
    rx_perr = q.pe_pend;
    // A read in the same cycle empties the old data in time
    rx_ovr = q.unread && !rx_read_in;
  end

  // Receiver, buffer, flags and interrupts
  always_comb begin
    d = q;
    d.err_irq = 1'b0;
    d.done_irq = 1'b0;
    d.fin = 1'b0;
    // Reading the buffer clears status; completion below wins
    if (rx_read_in) begin
      d.err = 3'h0;
      d.unread = 1'b0;
    end
    if (!rx_enable_bit_in) begin
      // Abort at once; buffer and flags stay as they are
      d.st = R_IDLE;
      d.idx = 4'h0000;
    end else begin
      unique case (q.st)
        R_IDLE: if (cif.rx_start) begin
          d.st = R_DATA;
          d.idx = 4'h0000;
          d.sh = RXB_RST;
          d.pe_pend = 1'b0;
        end
        R_DATA: if (cif.rx_bit_stb) begin
          if (q.idx == nchar &&
              (parity_mode_in == PAR_ODD ||
               parity_mode_in == PAR_EVEN)) begin
            // Parity slot is checked, not stored
            d.pe_pend = rx_pin_in != par_calc(q.sh,
                                              char_length_sel_in,
                                              parity_mode_in);
          end else if (q.idx != nchar ||
                       parity_mode_in == PAR_NONE) begin
            // LSB first into the shift register
            d.sh[q.idx[3:0]] = rx_pin_in;
          end
          d.idx = q.idx + 4'h0001;
          if (q.idx == npay - 4'h0001) begin
            d.st = R_STOP;
          end
        end
        R_STOP: if (cif.rx_bit_stb) begin
          d.st = R_IDLE;
          d.fin = 1'b1;
        end
        default: d.st = R_IDLE;
      endcase
    end
    // Completion: errored frames are still delivered
    if (rx_fin) begin
      d.rxb = q.sh;
      d.unread = 1'b1;
      d.err[ERR_PE] = rx_perr;
      d.err[ERR_FE] = rx_ferr;
      d.err[ERR_OVE] = rx_ovr;
      d.done_irq = 1'b1;
      d.err_irq = rx_perr || rx_ferr || rx_ovr;
    end
    // Code registered with the pulses; transmit joins at the output
    d.top = irq_pick(d.err_irq, d.done_irq, 1'b0);
  end

  // Highest pending request among this cycle's pulses
  function automatic logic [1:0] irq_pick(input logic e,
                                          input logic r,
                                          input logic t);
    if (e) begin
      return IRQ_RX_ERR;
    end else if (r) begin
      return IRQ_RX_DONE;
    end else if (t) begin
      return IRQ_TX_DONE;
    end
    return IRQ_NONE;
  endfunction

  // State register; the code follows the pulses it names
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '{st: R_IDLE, sh: RXB_RST, rxb: RXB_RST,
             top: IRQ_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs, all from flip-flops except the pin and top-code muxes
  assign tx_pin_out = cif.tx_line;
  assign tx_busy_out = cif.tx_busy;
  assign rx_buffer_out = q.rxb;
  assign async_error_status_out = q.err;
  assign rx_error_irq_out = q.err_irq;
  assign rx_done_irq_out = q.done_irq;
  assign tx_done_irq_out = cif.tx_last;
  assign irq_top_out = (q.top != IRQ_NONE) ? q.top :
                       (cif.tx_last ? IRQ_TX_DONE : IRQ_NONE);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  a_err_with_done: assert property (
    rx_error_irq_out |-> rx_done_irq_out)
    else $error("error irq without completion");
  a_err_only_rx_on: assert property (
    rx_error_irq_out |-> $past(rx_enable_bit_in))
    else $error("error irq while receive disabled");
  a_rx_off_quiet: assert property (
    !rx_enable_bit_in |=> !rx_done_irq_out &&
      $stable(rx_buffer_out))
    else $error("receiver active while disabled");
  a_tx_off_ignore: assert property (
    tx_write_in && !tx_enable_bit_in && !tx_busy_out |=>
      !tx_busy_out)
    else $error("write accepted while disabled");
  a_tx_write_start: assert property (
    tx_write_in && tx_enable_bit_in && !tx_busy_out |=>
      tx_busy_out)
    else $error("enabled write did not start");
  a_read_clears: assert property (
    rx_read_in && !rx_fin |=> async_error_status_out == 3'h0)
    else $error("status not cleared by read");
  a_upper_zero: assert property (
    rx_done_irq_out && !$past(char_length_sel_in) &&
      $past(parity_mode_in) != PAR_NONE |->
      rx_buffer_out[8:7] == 2'h0)
    else $error("buffer upper bits not zero");
  a_irq_priority: assert property (
    rx_error_irq_out |-> irq_top_out == IRQ_RX_ERR)
    else $error("error irq not on top");
  a_ovr_flag: assert property (
    rx_fin && q.unread && !rx_read_in |=>
      async_error_status_out[ERR_OVE] && rx_error_irq_out)
    else $error("overrun not flagged");
endmodule

// ### asc_remote_uart.sv
`timescale 1ns/1ns
// Far-side serial partner: drives frames into the receiver and captures
// the transmitter's frames by mid-bit sampling on the shared tick
module asc_remote_uart (
  input wire logic clock_in,
  input wire logic tick_in,
  input wire logic line_in,
  input wire logic [3:0] cap_len_in,
  output logic line_out,
  output logic [11:0] got_out,
  output logic [7:0] n_got_out
);
  logic hunt_ff; // A frame is being captured
  logic [7:0] cnt_ff; // Ticks since the falling edge was seen

  initial begin
    line_out = 1'b1; // Mark level while idle
    got_out = 12'h000;
    n_got_out = 8'h00;
    hunt_ff = 1'b0;
    cnt_ff = 8'h00;
  end

  // Sample 8 ticks after the edge, then every 16; stop after cap_len
  always @(posedge clock_in) begin
    if (tick_in === 1'b1) begin
      if (!hunt_ff) begin
        if (line_in === 1'b0) begin
          hunt_ff <= 1'b1;
          cnt_ff <= 8'h01;
          got_out <= 12'h000;
        end
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
        if (cnt_ff[3:0] == 4'h8) begin
          got_out[cnt_ff[7:4]] <= line_in;
          // Ends inside a stop bit, so the high line cannot re-trigger
          if (cnt_ff[7:4] == cap_len_in) begin
            hunt_ff <= 1'b0;
            n_got_out <= n_got_out + 8'h01;
          end
        end
      end
    end
  end

  // Frame bit 0 first, each bit held for bt ticks, then back to mark
  task automatic send(input logic [11:0] bits, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      line_out = bits[i];
      repeat (bt) begin
        @(posedge clock_in);
        while (tick_in !== 1'b1) @(posedge clock_in);
      end
      #1;
    end
    line_out = 1'b1;
  endtask
endmodule

// ### asc_top_tb.sv
`timescale 1ns/1ns
module asc_top_tb;
  import asc_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic tick = 1'b0; // Serial clock tick, every other cycle
  logic tx_en, rx_en, cl, sl, ext, tx_wr, rx_rd;
  logic [1:0] pm;
  logic [8:0] tx_data;
  logic [3:0] cap_len; // Captured bits after the start bit
  wire rx_line, tx_pin, busy, irq_e, irq_d, irq_t;
  wire [8:0] rxb;
  wire [2:0] st;
  wire [1:0] top;
  wire [11:0] got;
  wire [7:0] n_got;
  int n_errors = 0;
  int compares = 0;
  int evt[3] = '{0, 0, 0}; // Pulses seen: tx done, rx done, rx error
  logic pin_at_done, err_with_done;
  logic [1:0] top_seen;

  always #2 clock_in = ~clock_in;
  // Short bit times keep the run brief: 16 ticks are 32 cycles
  always @(posedge clock_in) tick <= #1 ~tick;

  asc_top u_asc_top (.clock_in(clock_in), .srst_in(srst_in),
    .sample_tick_in(tick), .tx_enable_bit_in(tx_en),
    .rx_enable_bit_in(rx_en), .char_length_sel_in(cl),
    .stop_length_sel_in(sl), .parity_mode_in(pm), .ext_bit_en_in(ext),
    .tx_write_in(tx_wr), .tx_shift_reg_in(tx_data), .rx_read_in(rx_rd),
    .rx_pin_in(rx_line), .tx_pin_out(tx_pin), .tx_busy_out(busy),
    .rx_buffer_out(rxb), .async_error_status_out(st),
    .rx_error_irq_out(irq_e), .rx_done_irq_out(irq_d),
    .tx_done_irq_out(irq_t), .irq_top_out(top));

  asc_remote_uart u_asc_remote_uart (.clock_in(clock_in), .tick_in(tick),
    .line_in(tx_pin), .cap_len_in(cap_len), .line_out(rx_line),
    .got_out(got), .n_got_out(n_got));

  // Count interrupt pulses and keep what stood beside them
  always @(posedge clock_in) begin
    if (irq_t === 1'b1) begin
      evt[0]++;
      pin_at_done = tx_pin;
    end
    if (irq_d === 1'b1) begin
      evt[1]++;
      err_with_done = irq_e;
    end
    if (irq_e === 1'b1) evt[2]++;
    if ((irq_t | irq_d | irq_e) === 1'b1) top_seen = top;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for a pulse counter to reach its goal
  task automatic wait_evt(input int sel, input int goal);
    for (int i = 0; i < 3000; i++) begin
      if (evt[sel] >= goal) return;
      cyc(1);
    end
    n_errors++;
    complete_run();
  endtask

  task automatic tx_write(input logic [8:0] d);
    tx_data = d;
    tx_wr = 1'b1;
    cyc(1);
    tx_wr = 1'b0;
  endtask

  task automatic rx_read();
    rx_rd = 1'b1;
    cyc(1);
    rx_rd = 1'b0;
  endtask

  // Seven-bit frame with parity and two stops; only the first is checked
  function automatic logic [11:0] f7(input logic [6:0] d, input logic p,
                                     input logic s);
    return {1'b0, 1'b1, s, p, d, 1'b0};
  endfunction

  task automatic rx_frame(input logic [11:0] bits);
    u_asc_remote_uart.send(bits, 11, 16);
    cyc(4);
  endtask

  initial begin
    // Transmit and receive enabled; 8-bit even parity, one stop bit
    tx_en = 1'b1;
    rx_en = 1'b1;
    cl = 1'b1;
    sl = 1'b0;
    pm = PAR_EVEN;
    ext = 1'b0;
    tx_wr = 1'b0;
    rx_rd = 1'b0;
    tx_data = 9'h000;
    cap_len = 4'hA;
    cyc(5);
    srst_in = 1'b0;
    cyc(1);
    // Idle state after reset
    chk(tx_pin, 1'b1);
    chk(rxb, 9'h000);
    chk({busy, st}, 4'h0);
    // 8-bit even parity frame; second write while busy is discarded
    tx_write(9'h0A5);
    chk(busy, 1'b1);
    cyc(1);
    tx_write(9'h0FF);
    wait_evt(0, 1);
    chk(pin_at_done, 1'b1);
    chk(top_seen, IRQ_TX_DONE);
    cyc(40);
    chk(got, {1'b1, 1'b0, 8'hA5, 1'b0});
    chk(n_got, 8'h01);
    cyc(400);
    chk(12'(evt[0]), 12'h001);
    // Writes with the transmitter disabled leave the line alone
    tx_en = 1'b0;
    tx_write(9'h000);
    cyc(40);
    chk({busy, tx_pin, n_got}, {2'b01, 8'h01});
    tx_en = 1'b1;
    // 7-bit odd parity, two stops, both directions at once
    cl = 1'b0;
    pm = PAR_ODD;
    sl = 1'b1;
    fork
      tx_write(9'h055);
      rx_frame(f7(7'h31, 1'b0, 1'b1));
    join
    wait_evt(0, 2);
    cyc(40);
    chk(got, {1'b1, 1'b1, 1'b1, 7'h55, 1'b0});
    chk(12'(evt[1]), 12'h001);
    chk(rxb, 9'h031);
    chk(st, 3'b000);
    rx_read();
    // Parity error: both pulses together, frame still stored
    rx_frame(f7(7'h12, 1'b0, 1'b1));
    chk(err_with_done, 1'b1);
    chk(top_seen, IRQ_RX_ERR);
    chk(st, 3'b100);
    chk(rxb, 9'h012);
    // Unread buffer overwritten; parity flag replaced by overrun
    rx_frame(f7(7'h21, 1'b1, 1'b1));
    chk(st, 3'b001);
    chk(rxb, 9'h021);
    chk(12'(evt[2]), 12'h002);
    rx_read();
    chk(st, 3'b000);
    // First stop bit low gives a framing error
    rx_frame(f7(7'h40, 1'b0, 1'b0));
    chk(st, 3'b010);
    rx_read();
    // A short low pulse is rejected, the next frame still lands
    u_asc_remote_uart.send(12'h000, 1, 4);
    cyc(400);
    chk(12'(evt[1]), 12'h004);
    rx_frame(f7(7'h31, 1'b0, 1'b1));
    chk(rxb, 9'h031);
    chk(top_seen, IRQ_RX_DONE);
    // Disable mid-frame, then a whole frame while disabled
    fork
      rx_frame(f7(7'h12, 1'b1, 1'b1));
      begin
        cyc(100);
        rx_en = 1'b0;
      end
    join
    chk(12'(evt[1]), 12'h005);
    chk({st, rxb}, 12'h031);
    rx_frame(f7(7'h21, 1'b1, 1'b1));
    chk(12'(evt[1]), 12'h005);
    chk(12'(evt[2]), 12'h003);
    chk(rxb, 9'h031);
    rx_en = 1'b1;
    // Nine-bit characters with the expansion bit, one stop bit
    rx_read();
    cl = 1'b1;
    pm = PAR_NONE;
    ext = 1'b1;
    sl = 1'b0;
    fork
      tx_write(9'h1C3);
      rx_frame(12'h6B4);
    join
    wait_evt(0, 3);
    cyc(40);
    chk(got, {1'b1, 1'b1, 8'hC3, 1'b0});
    chk(rxb, 9'h15A);
    chk(st, 3'b000);
    // Reset in mid-frame empties the shifter without a pulse
    tx_write(9'h033);
    cyc(100);
    srst_in = 1'b1;
    cyc(1);
    srst_in = 1'b0;
    chk({busy, tx_pin}, 2'b01);
    cyc(500);
    chk(12'(evt[0]), 12'h003);
    complete_run();
  end
endmodule
